// File: hdl/cswd_pkg.sv
// constants, register map and types for the clock supervisor and watchdog
// assumes a single 20 MHz system clock and a synchronous internal rc tick input
package cswd_pkg;
    localparam int          CLK_FREQ_HZ      = 20_000_000;
    localparam int          WDT_BASE_US      = 4000;
    localparam int          RC_FREQ_HZ       = 31_250;
    localparam int          WDT_BASE_TICKS   = (WDT_BASE_US * RC_FREQ_HZ) / 1_000_000;
    localparam int          WDT_POST_BITS    = 16;
    localparam int          FAIL_SAFE_MONITOR_DIV         = 64;
    localparam int          FAIL_SAFE_MONITOR_DIV_BITS    = $clog2(FAIL_SAFE_MONITOR_DIV);

    localparam logic [3:0]  ADDR_WDT_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_OSC_CTRL    = 4'h1;
    localparam logic [3:0]  ADDR_IRQ_FLAGS2  = 4'h2;

    localparam int          WDT_SOFT_EN_BIT  = 0;
    localparam int          OSC_FREQ_LSB     = 4;
    localparam int          OSC_ACTIVE_BIT   = 3;
    localparam int          OSC_SEL_LSB      = 0;
    localparam int          IRQ_FAIL_BIT     = 7;

    localparam logic [7:0]  WDT_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  OSC_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  IRQ_FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  OSC_CTRL_WMASK   = 8'h73;

    localparam logic [1:0]  SEL_PRIMARY      = 2'h0;
    localparam logic [1:0]  SEL_SECONDARY    = 2'h1;

    typedef enum logic [2:0] {
        SRC_START     = 3'b000,
        SRC_PRIMARY   = 3'b001,
        SRC_SECONDARY = 3'b010,
        SRC_INTERNAL  = 3'b011,
        SRC_FAILSAFE  = 3'b100
    } cswd_src_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } cswd_bus_t;

    typedef struct packed {
        logic       wdt_en;
        logic [3:0] wdt_tap;
        logic       two_speed;
        logic       monitor_en;
    } cswd_cfg_t;
endpackage

// File: hdl/cswd_top.sv
// clock supervisor: watchdog, two-speed start-up and fail-safe clock monitor
// assumes all inputs are synchronous to i_clk; i_rc_tick pulses once per internal rc period
// Functional notes
// - watchdog counts internal rc ticks, base period nominally 4 ms
// - 16-bit postscaler, configured tap gives 4 ms up to 131.072 s
// - sleep, clear-watchdog, frequency-select change or clock failure clear watchdog counts
// - internal rc runs whenever the watchdog is enabled
// - soft enable bit 0 resets to 0, acts only if config leaves watchdog off
// - two-speed: run internal after reset or wake until start-up timer expires
// - reset clears oscillator control, so internal rc runs at base frequency
// - outside reset and wake, two-speed setting ignored; mode entry to a primary not yet ready runs internal until ready
// - oscillator control bit 3 set while primary clocks the device
// - monitor enabled keeps internal rc running continuously
// - sample clock is internal rc divided by 64
// - latch set on device clock fall, cleared on sample clock rise
// - failure declared when latch still set at sample clock fall
// - failure sets fail flag at bit 7 of interrupt flags register two
// - failure switches to internal block without updating oscillator control
// - only primary or secondary clock failures are detected
// - watchdog has own divider, disabling it leaves rc running for monitor
// - fail-safe ends only on reset or power-managed mode entry
// - after reset, internal clocks until primary ready, then status set, monitoring resumes
// - primary never ready: stay internal, oscillator control held at reset value
// - failure in power-managed mode: stay internal, never switch back automatically
`timescale 1ns/1ps
`default_nettype none
module cswd_top
    import cswd_pkg::*;
#(
    parameter int BASE_TICKS = WDT_BASE_TICKS,
    parameter int POST_BITS  = WDT_POST_BITS
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_ce,
    input  wire cswd_bus_t  i_bus,
    input  wire cswd_cfg_t  i_cfg,
    input  wire logic       i_rc_tick,
    input  wire logic       i_dev_clk,
    input  wire logic       i_primary_ready,
    input  wire logic       i_sleep,
    input  wire logic       i_wake,
    input  wire logic       i_clear_watchdog_instr,
    input  wire logic       i_pm_enter,
    output logic [7:0]      o_rdata,
    output logic            o_wdt_timeout,
    output logic            o_rc_on,
    output logic [2:0]      o_clk_src,
    output logic            o_rc_base
);
    localparam int BASE_W = $clog2(BASE_TICKS + 1);

    function automatic logic tap_hit(input logic [POST_BITS-1:0] cnt, input logic [3:0] tap);
        logic [POST_BITS-1:0] mask;
        mask = (POST_BITS'(1) << tap) - POST_BITS'(1);
        return (cnt & mask) == mask;
    endfunction

    cswd_src_t              src_q, src_d;
    logic [7:0]             wdt_ctrl_q;
    logic [7:0]             osc_ctrl_q, osc_ctrl_d;
    logic [7:0]             irq_q, irq_d;
    logic [BASE_W-1:0]      base_q;
    logic [POST_BITS-1:0]   post_q;
    logic [FAIL_SAFE_MONITOR_DIV_BITS-1:0] div_q;
    logic                   samp_q;
    logic                   dev_q;
    logic                   latch_q;

    // bus decode
    wire wr_wdt = i_bus.we && (i_bus.addr == ADDR_WDT_CTRL);
    wire wr_osc = i_bus.we && (i_bus.addr == ADDR_OSC_CTRL);
    wire wr_irq = i_bus.we && (i_bus.addr == ADDR_IRQ_FLAGS2);

    // watchdog enable: soft bit only matters while config leaves it off
    wire wdt_on = i_cfg.wdt_en | wdt_ctrl_q[WDT_SOFT_EN_BIT];
    // watchdog has its own divider, so rc stays on for the monitor regardless
    wire rc_on  = wdt_on | i_cfg.monitor_en;

    // sample clock: rc divided by 64, its msb is the square wave
    wire samp     = div_q[FAIL_SAFE_MONITOR_DIV_BITS-1];
    wire samp_rise = samp && !samp_q;
    wire samp_fall = !samp && samp_q;
    wire dev_fall  = dev_q && !i_dev_clk;

    // internal block failures are invisible: watch only external sources
    wire monitoring = i_cfg.monitor_en && ((src_q == SRC_PRIMARY) || (src_q == SRC_SECONDARY));
    wire fail      = i_ce && monitoring && samp_fall && latch_q;

    // frequency select change counts as a watchdog clear event
    wire freq_chg  = wr_osc && (i_bus.wdata[OSC_FREQ_LSB +: 3] != osc_ctrl_q[OSC_FREQ_LSB +: 3]);
    wire wdt_clr   = i_sleep | i_clear_watchdog_instr | freq_chg | fail;
    wire base_end  = i_rc_tick && (base_q == BASE_W'(BASE_TICKS - 1));
    wire wdt_fire  = wdt_on && base_end && tap_hit(post_q, i_cfg.wdt_tap);

    // clock source sequencing
    always_comb begin
        src_d      = src_q;
        osc_ctrl_d = osc_ctrl_q;
        if (wr_osc) begin
            osc_ctrl_d = (osc_ctrl_q & ~OSC_CTRL_WMASK) | (i_bus.wdata & OSC_CTRL_WMASK);
        end
        case (src_q)
            SRC_START: begin
                // waiting on the start-up timer; control register stays at reset status
                if (i_primary_ready) begin
                    src_d = SRC_PRIMARY;
                end
            end
            SRC_PRIMARY, SRC_SECONDARY: begin
                if (fail) begin
                    src_d = SRC_FAILSAFE;
                end
            end
            SRC_INTERNAL: begin
                src_d = SRC_INTERNAL;
            end
            SRC_FAILSAFE: begin
                src_d = SRC_FAILSAFE;
            end
            default: begin
                src_d = SRC_START;
            end
        endcase
        // power-managed entry picks the source named in the control register
        if (i_pm_enter && !fail) begin
            if (osc_ctrl_d[OSC_SEL_LSB +: 2] == SEL_PRIMARY) begin
                src_d = i_primary_ready ? SRC_PRIMARY : SRC_START;
            end else if (osc_ctrl_d[OSC_SEL_LSB +: 2] == SEL_SECONDARY) begin
                src_d = SRC_SECONDARY;
            end else begin
                src_d = SRC_INTERNAL;
            end
        end
        // wake from sleep restarts two-speed only when configured; otherwise wait on primary
        // a failure in the same cycle wins, so a wake cannot hide it
        if (i_wake && !i_pm_enter && !fail && (src_q != SRC_FAILSAFE)) begin
            src_d = (i_cfg.two_speed || !i_primary_ready) ? SRC_START : SRC_PRIMARY;
        end
        // status bit tracks primary; fail-safe leaves the register untouched
        if (src_d == SRC_PRIMARY) begin
            osc_ctrl_d[OSC_ACTIVE_BIT] = 1'b1;
        end else if ((src_d != SRC_FAILSAFE) && (src_q != SRC_FAILSAFE || i_pm_enter)) begin
            osc_ctrl_d[OSC_ACTIVE_BIT] = 1'b0;
        end
    end

    // fail flag: hardware set wins over a software clear in the same cycle
    always_comb begin
        irq_d = irq_q;
        if (wr_irq) begin
            irq_d[IRQ_FAIL_BIT] = i_bus.wdata[IRQ_FAIL_BIT];
        end
        if (fail) begin
            irq_d[IRQ_FAIL_BIT] = 1'b1;
        end
    end

    wire [7:0] rd_mux = (i_bus.addr == ADDR_WDT_CTRL)   ? wdt_ctrl_q :
                        (i_bus.addr == ADDR_OSC_CTRL)   ? osc_ctrl_q :
                        (i_bus.addr == ADDR_IRQ_FLAGS2) ? irq_q      : 8'h00;

    // internal clock runs undivided until a frequency is selected after reset
    wire rc_base_d = (osc_ctrl_d[OSC_FREQ_LSB +: 3] == 3'h0);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_q      <= SRC_START;
            osc_ctrl_q <= OSC_CTRL_RESET;
            irq_q      <= IRQ_FLAGS_RESET;
            wdt_ctrl_q <= WDT_CTRL_RESET;
        end else if (i_ce) begin
            src_q      <= src_d;
            osc_ctrl_q <= osc_ctrl_d;
            irq_q      <= irq_d;
            if (wr_wdt) begin
                wdt_ctrl_q <= {7'h00, i_bus.wdata[WDT_SOFT_EN_BIT]};
            end
        end
    end

    // watchdog base divider and postscaler
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            base_q <= '0;
            post_q <= '0;
        end else if (i_ce) begin
            if (wdt_clr || wdt_fire || !wdt_on) begin
                base_q <= '0;
                post_q <= '0;
            end else if (base_end) begin
                base_q <= '0;
                post_q <= post_q + POST_BITS'(1);
            end else if (i_rc_tick) begin
                base_q <= base_q + BASE_W'(1);
            end
        end
    end

    // monitor divider and latch; a set and a clear together leave the latch set
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_q   <= '0;
            samp_q  <= 1'b0;
            dev_q   <= 1'b0;
            latch_q <= 1'b0;
        end else if (i_ce) begin
            if (i_rc_tick && rc_on) begin
                div_q <= div_q + FAIL_SAFE_MONITOR_DIV_BITS'(1);
            end
            samp_q <= samp;
            dev_q  <= i_dev_clk;
            if (dev_fall) begin
                latch_q <= 1'b1;
            end else if (samp_rise) begin
                latch_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata       <= 8'h00;
            o_wdt_timeout <= 1'b0;
            o_rc_on       <= 1'b0;
            o_clk_src     <= SRC_START;
            o_rc_base     <= 1'b1;
        end else if (i_ce) begin
            o_rdata       <= i_bus.re ? rd_mux : 8'h00;
            o_wdt_timeout <= wdt_fire;
            o_rc_on       <= rc_on;
            o_clk_src     <= src_d;
            o_rc_base     <= rc_base_d;
        end
    end

    a_fail_sets_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fail |=> irq_q[IRQ_FAIL_BIT]) else $error("fail flag not set after failure");

    a_fail_clears_wdt: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fail |=> (base_q == '0) && (post_q == '0)) else $error("watchdog not cleared on failure");

    a_fail_to_safe: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fail && !i_pm_enter |=> src_q == SRC_FAILSAFE ##0 o_clk_src == SRC_FAILSAFE)
        else $error("no switch to fail-safe source");

    a_safe_keeps_status: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fail |=> osc_ctrl_q[OSC_ACTIVE_BIT] == $past(osc_ctrl_q[OSC_ACTIVE_BIT]))
        else $error("control status changed on fail-safe entry");

    a_safe_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q == SRC_FAILSAFE) && i_ce && !i_pm_enter |=> src_q == SRC_FAILSAFE)
        else $error("fail-safe left without mode entry");

    a_internal_unwatched: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q inside {SRC_START, SRC_INTERNAL, SRC_FAILSAFE}) |-> !fail)
        else $error("failure seen on internal source");

    a_rc_on_follows: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_resetn |=> o_rc_on == ($past(i_cfg.wdt_en) | $past(wdt_ctrl_q[0]) | $past(i_cfg.monitor_en)))
        else $error("rc enable wrong");

    a_soft_en_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_bus.re && (i_bus.addr == ADDR_WDT_CTRL) |=> o_rdata[7:1] == 7'h00)
        else $error("watchdog control upper bits not zero");

    a_freq_chg_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && freq_chg |=> post_q == '0) else $error("frequency change did not clear postscaler");

    a_primary_status: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && (src_q == SRC_START) && i_primary_ready && !i_pm_enter && !i_wake
        |=> osc_ctrl_q[OSC_ACTIVE_BIT] ##0 src_q == SRC_PRIMARY)
        else $error("primary status not set on switch");

    a_start_waits: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q == SRC_START) && !i_primary_ready && !i_pm_enter |=> src_q == SRC_START)
        else $error("left start without primary ready");

    // counters held at zero while off, so a late enable always starts a full period
    a_wdt_off_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && !wdt_on |=> (base_q == '0) && (post_q == '0))
        else $error("watchdog counts while disabled");

    a_clr_counts: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && wdt_clr |=> (base_q == '0) && (post_q == '0))
        else $error("watchdog not cleared by clear event");

    a_rc_with_wdt: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_resetn && wdt_on |=> o_rc_on)
        else $error("rc off while watchdog enabled");

    a_rc_with_monitor: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_resetn && i_cfg.monitor_en |=> o_rc_on)
        else $error("rc off while monitor enabled");

    a_soft_en_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && wr_wdt |=> wdt_ctrl_q == {7'h00, $past(i_bus.wdata[WDT_SOFT_EN_BIT])})
        else $error("watchdog control write wrong");

    // the sample clock divider only advances on rc ticks while rc is requested
    a_div_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_resetn && i_rc_tick && rc_on |=> div_q == $past(div_q) + FAIL_SAFE_MONITOR_DIV_BITS'(1))
        else $error("sample divider did not step");

    a_latch_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && i_resetn && dev_fall |=> latch_q)
        else $error("monitor latch not set on device clock fall");

    a_latch_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && samp_rise && !dev_fall |=> !latch_q)
        else $error("monitor latch not cleared on sample rise");

    a_primary_flagged: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q == SRC_PRIMARY) |-> osc_ctrl_q[OSC_ACTIVE_BIT])
        else $error("primary running without status bit");

    a_internal_status: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q inside {SRC_START, SRC_SECONDARY, SRC_INTERNAL}) |-> !osc_ctrl_q[OSC_ACTIVE_BIT])
        else $error("status bit set while not on primary");

    a_pm_leaves_safe: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (src_q == SRC_FAILSAFE) && i_ce && i_pm_enter |=> src_q != SRC_FAILSAFE)
        else $error("mode entry did not end fail-safe");

    a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce && irq_q[IRQ_FAIL_BIT] && !wr_irq |=> irq_q[IRQ_FAIL_BIT])
        else $error("fail flag dropped without a write");
endmodule
`default_nettype wire

// File: test/cswd_osc_model.sv
// far-side model: crystal primary oscillator with start-up delay and a failure switch
// assumes the bench drives i_run (crystal powered) and i_fail (oscillation lost)
`timescale 1ns/1ps
`default_nettype none
module cswd_osc_model #(
    parameter int STARTUP = 60
) (
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic       i_fail,
    input  wire logic [3:0] i_half,
    output logic            o_dev_clk,
    output logic            o_primary_ready
);
    int   cnt   = 0;
    int   ph    = 0;
    logic dev_q = 1'b0;
    logic rdy_q = 1'b0;
    assign o_dev_clk       = dev_q;
    assign o_primary_ready = rdy_q;
    always @(posedge i_clk) begin
        // crystal only: never ready at once, always after a start-up delay
        cnt <= i_run ? cnt + 1 : 0;
        rdy_q <= i_run && (cnt >= STARTUP);
        ph <= (ph + 1 >= int'(i_half)) ? 0 : ph + 1;
        // a held crystal stands still instead of toggling on
        if (i_run && !i_fail && (ph + 1 >= int'(i_half))) begin
            dev_q <= ~dev_q;
        end
    end
endmodule
`default_nettype wire

// File: test/cswd_top_tb_top.sv
// self-checking bench for the clock supervisor and watchdog
// assumes rc ticks every 4 system clocks and a shortened watchdog base count
`timescale 1ns/1ps
`default_nettype none
module cswd_top_tb_top;
    import cswd_pkg::*;
    localparam int BT = 3;
    logic       i_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic       ce = 1'b1;
    cswd_bus_t  bus = '0;
    cswd_cfg_t  cfg = '{wdt_en: 1'b0, wdt_tap: 4'h0, two_speed: 1'b1, monitor_en: 1'b1};
    logic       rc_tick = 1'b0;
    logic [1:0] rc_cnt = 2'h0;
    logic [3:0] ev = 4'h0;
    // only falling device clock edges set the monitor latch, so a held clock stays unflagged
    logic       dev_clk, ready, run = 1'b0, fail = 1'b1;
    logic [3:0] half = 4'h3;
    logic [7:0] rdata;
    logic [2:0] src;
    logic       to, rc_on, rc_base;
    int         miscompares = 0;
    int         comparisons = 0;

    always #25 i_clk = ~i_clk;
    // rc tick is free running: the slow oscillator ignores the system clock enable
    always @(posedge i_clk) begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_tick <= (rc_cnt == 2'h3);
    end

    cswd_top #(.BASE_TICKS(BT), .POST_BITS(16)) cswd_top_i (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_bus(bus), .i_cfg(cfg),
        .i_rc_tick(rc_tick), .i_dev_clk(dev_clk), .i_primary_ready(ready),
        .i_sleep(ev[0]), .i_wake(ev[1]), .i_clear_watchdog_instr(ev[2]), .i_pm_enter(ev[3]),
        .o_rdata(rdata), .o_wdt_timeout(to), .o_rc_on(rc_on), .o_clk_src(src), .o_rc_base(rc_base));
    cswd_osc_model cswd_osc_model_i (
        .i_clk(i_clk), .i_run(run), .i_fail(fail), .i_half(half),
        .o_dev_clk(dev_clk), .o_primary_ready(ready));

    task automatic give_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_clk);
        bus.we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge i_clk);
        bus.re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse(input int k);
        @(posedge i_clk);
        ev <= 4'h1 << k;
        @(posedge i_clk);
        ev <= 4'h0;
    endtask
    task automatic wait_src(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (src !== s && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        chk({5'h0, src}, {5'h0, s});
        if (src !== s) give_verdict();
    endtask
    task automatic wait_to(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (to !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // crystal is powered again only after reset, as a real restart would be
    task automatic do_reset(input logic start);
        i_resetn <= 1'b0;
        run <= 1'b0;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        run <= start;
    endtask

    initial begin
        logic [7:0] d;
        int n, p;
        void'($urandom(32'h84f6_32dc));
        half <= 4'($urandom_range(2, 9));
        do_reset(1'b1);
        #1 chk({5'h0, src}, {5'h0, SRC_START});
        chk({7'h0, rc_base}, 8'h01);
        rd(4'h1, d);
        chk(d, OSC_CTRL_RESET);
        wait_src(SRC_PRIMARY, 200);
        rd(4'h1, d);
        chk(d, 8'h08);
        rd(4'h0, d);
        chk(d, WDT_CTRL_RESET);
        rd(4'hf, d);
        chk(d, 8'h00);
        wr(4'h0, 8'hff);
        rd(4'h0, d);
        chk(d, 8'h01);
        chk({7'h0, rc_on}, 8'h01);
        // watchdog period for random taps: base count doubled per tap step
        repeat (3) begin
            cfg.wdt_tap <= 4'($urandom_range(0, 3));
            pulse(2);
            p = BT * (1 << cfg.wdt_tap) * 4;
            wait_to(n);
            wait_to(n);
            chk(8'(n), 8'(p));
        end
        // sleep, clear and frequency change each restart the count mid-period
        for (int k = 0; k < 3; k++) begin
            wait_to(n);
            repeat (p / 2) @(posedge i_clk);
            if (k == 2)
                wr(4'h1, 8'h10);
            else
                pulse(2 * k);
            wait_to(n);
            chk(8'(n >= p - 6 && n <= p + 6), 8'h01);
            if (k == 0) pulse(1);
        end
        chk({7'h0, rc_base}, 8'h00);
        wr(4'h0, 8'h00);
        repeat (2) @(posedge i_clk);
        chk({7'h0, rc_on}, 8'h01);
        cfg.monitor_en <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk({7'h0, rc_on}, 8'h00);
        cfg.monitor_en <= 1'b1;
        wait_src(SRC_PRIMARY, 200);
        repeat (600) @(posedge i_clk);
        chk({5'h0, src}, {5'h0, SRC_PRIMARY});
        // clock edges while the enable is low must not reach the monitor
        ce <= 1'b0;
        fail <= 1'b0;
        repeat (600) @(posedge i_clk);
        chk({5'h0, src}, {5'h0, SRC_PRIMARY});
        ce <= 1'b1;
        wait_src(SRC_FAILSAFE, 1200);
        rd(4'h2, d);
        chk(d, 8'h80);
        rd(4'h1, d);
        chk(d, 8'h18);
        pulse(1);
        fail <= 1'b1;
        repeat (600) @(posedge i_clk);
        chk({5'h0, src}, {5'h0, SRC_FAILSAFE});
        wr(4'h1, 8'h12);
        pulse(3);
        wait_src(SRC_INTERNAL, 10);
        rd(4'h1, d);
        chk(d, 8'h12);
        fail <= 1'b0;
        repeat (600) @(posedge i_clk);
        chk({5'h0, src}, {5'h0, SRC_INTERNAL});
        wr(4'h2, 8'h00);
        rd(4'h2, d);
        chk(d, 8'h00);
        fail <= 1'b1;
        do_reset(1'b0);
        repeat (100) @(posedge i_clk);
        chk({5'h0, src}, {5'h0, SRC_START});
        rd(4'h1, d);
        chk(d, OSC_CTRL_RESET);
        run <= 1'b1;
        wait_src(SRC_PRIMARY, 200);
        give_verdict();
    end
endmodule
`default_nettype wire
